// *** drcl_chan_decode.sv ***
// Turns one channel's stored fields into control levels for the analog side.
// Purely combinational; its caller registers the results.
`timescale 1ns/1ns
module drcl_chan_decode (
  input drcl_pkg::drcl_chan_cfg_t cfg_in,
  output drcl_pkg::drcl_chan_ctrl_t ctrl_out
);

  always_comb begin
    ctrl_out.rx_clock_half_rate = cfg_in.rx_clock_rate_sel;
    ctrl_out.primary_detect_level = cfg_in.primary_detect_level;
    ctrl_out.secondary_detect_level = cfg_in.secondary_detect_level;
    ctrl_out.training_clock_double = cfg_in.training_clock_double;
    ctrl_out.rx_channel_power_on = cfg_in.rx_channel_power_on;
    ctrl_out.video_rx_en = (cfg_in.rx_test_mode_sel == drcl_pkg::TEST_VIDEO);
    ctrl_out.self_test_en = (cfg_in.rx_test_mode_sel == drcl_pkg::TEST_SELF);
    // Invalid codes select neither mode
    ctrl_out.test_mode_invalid = !(ctrl_out.video_rx_en || ctrl_out.self_test_en);
    ctrl_out.reclock_primary_drive_en = cfg_in.reclock_primary_drive_en;
    ctrl_out.reclock_secondary_drive_en = cfg_in.reclock_secondary_drive_en;
    ctrl_out.reclock_logic_power_on = cfg_in.reclock_primary_drive_en ||
      cfg_in.reclock_secondary_drive_en;
  end

endmodule

// *** drcl_chan_latch.sv ***
// One channel's three configuration banks.
// Assumes write strobe, address and data are already synchronised to clock_in.
`timescale 1ns/1ns
module drcl_chan_latch (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic write_in,
  input wire logic [2:0] bank_sel_in,
  input wire logic [6:0] data_in,
  output drcl_pkg::drcl_chan_cfg_t cfg_out
);

  drcl_pkg::drcl_chan_cfg_t cfg_reg;

  assign cfg_out = cfg_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bank_sel_in is one-hot: clock, detect, dynamic
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cfg_reg.rx_clock_rate_sel <= drcl_pkg::RST_CLK_RATE;
      cfg_reg.secondary_detect_level <= drcl_pkg::RST_DET;
      cfg_reg.primary_detect_level <= drcl_pkg::RST_DET;
      cfg_reg.training_clock_double <= drcl_pkg::RST_TRG_DBL;
      cfg_reg.rx_channel_power_on <= drcl_pkg::RST_PWR;
      cfg_reg.rx_test_mode_sel <= drcl_pkg::RST_TEST;
      cfg_reg.reclock_secondary_drive_en <= drcl_pkg::RST_DRV;
      cfg_reg.reclock_primary_drive_en <= drcl_pkg::RST_DRV;
    end else if (write_in) begin
      // Fixed and don't-care positions are not stored
      if (bank_sel_in[0]) begin
        cfg_reg.rx_clock_rate_sel <= data_in[drcl_pkg::CLK_RATE_BIT];
      end
      if (bank_sel_in[1]) begin
        cfg_reg.secondary_detect_level <=
          data_in[drcl_pkg::SEC_DET_HI:drcl_pkg::SEC_DET_LO];
        cfg_reg.primary_detect_level <=
          data_in[drcl_pkg::PRI_DET_HI:drcl_pkg::PRI_DET_LO];
        cfg_reg.training_clock_double <= data_in[drcl_pkg::TRG_DBL_BIT];
      end
      if (bank_sel_in[2]) begin
        cfg_reg.rx_test_mode_sel <=
          {data_in[drcl_pkg::TEST_HI_BIT], data_in[drcl_pkg::TEST_LO_BIT]};
        cfg_reg.rx_channel_power_on <= data_in[drcl_pkg::PWR_BIT];
        cfg_reg.reclock_secondary_drive_en <= data_in[drcl_pkg::SEC_DRV_BIT];
        cfg_reg.reclock_primary_drive_en <= data_in[drcl_pkg::PRI_DRV_BIT];
      end
    end
  end

endmodule

// *** drcl_host_model.sv ***
// Host that writes configuration banks over the strobe, address and data pins.
// Assumes the caller sequences writes; each task call is one whole bank write.
`timescale 1ns/1ns
module drcl_host_model (
  input wire logic clock_in,
  output logic config_write_strobe_n_out,
  output logic [2:0] config_addr_out,
  output logic [6:0] config_data_out
);
  initial begin
    config_write_strobe_n_out = 1'h1;
    config_addr_out = 3'h3;
    config_data_out = 7'h00;
  end
  ////////////////////////////////////////////////////////////////
  // Speed range pin taken as high, so training double may be set
  task automatic write_bank(input logic [2:0] addr, input logic [6:0] data, input int hold);
    logic [6:0] pin_data;
    // Fixed positions forced before the pins move, so each pin changes once
    pin_data = data;
    if (addr == 3'h0 || addr == 3'h5) begin
      pin_data = (data & 7'h19) | 7'h40;
    end
    @(posedge clock_in) #5;
    config_addr_out = addr;
    config_data_out = pin_data;
    // Address settles ahead of the strobe for the synchroniser
    repeat (2) @(posedge clock_in);
    #5 config_write_strobe_n_out = 1'h0;
    repeat (hold) @(posedge clock_in);
    #5 config_write_strobe_n_out = 1'h1;
    repeat (3) @(posedge clock_in);
  endtask
endmodule

// *** drcl_pkg.sv ***
// Package for the dual-channel receive configuration latch bank.
// Assumes a single 20 MHz clock domain; all users reference items as drcl_pkg::name.
package drcl_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 7;

  // Bank addresses
  localparam logic [2:0] ADDR_A_CLOCK = 3'h0;
  localparam logic [2:0] ADDR_A_DETECT = 3'h1;
  localparam logic [2:0] ADDR_A_DYN = 3'h2;
  localparam logic [2:0] ADDR_B_CLOCK = 3'h5;
  localparam logic [2:0] ADDR_B_DETECT = 3'h6;
  localparam logic [2:0] ADDR_B_DYN = 3'h7;

  // Static clock bank field
  localparam int CLK_RATE_BIT = 0;
  // Static detect bank fields
  localparam int SEC_DET_HI = 6;
  localparam int SEC_DET_LO = 5;
  localparam int PRI_DET_HI = 4;
  localparam int PRI_DET_LO = 3;
  localparam int TRG_DBL_BIT = 0;
  // Dynamic bank fields
  localparam int TEST_HI_BIT = 6;
  localparam int PWR_BIT = 5;
  localparam int TEST_LO_BIT = 4;
  localparam int SEC_DRV_BIT = 2;
  localparam int PRI_DRV_BIT = 1;

  // Detector level codes
  localparam logic [1:0] DET_OFF = 2'h0;
  localparam logic [1:0] DET_140MV = 2'h1;
  localparam logic [1:0] DET_280MV = 2'h2;
  localparam logic [1:0] DET_420MV = 2'h3;

  // Test mode codes
  localparam logic [1:0] TEST_VIDEO = 2'h1;
  localparam logic [1:0] TEST_SELF = 2'h2;

  // Reset values
  localparam logic RST_CLK_RATE = 1'h1;
  localparam logic [1:0] RST_DET = DET_280MV;
  localparam logic RST_TRG_DBL = 1'h0;
  localparam logic RST_PWR = 1'h0;
  localparam logic [1:0] RST_TEST = 2'h3;
  localparam logic RST_DRV = 1'h0;

  typedef struct packed {
    logic rx_clock_rate_sel;
    logic [1:0] secondary_detect_level;
    logic [1:0] primary_detect_level;
    logic training_clock_double;
    logic rx_channel_power_on;
    logic [1:0] rx_test_mode_sel;
    logic reclock_secondary_drive_en;
    logic reclock_primary_drive_en;
  } drcl_chan_cfg_t;

  typedef struct packed {
    logic rx_clock_half_rate;
    logic [1:0] primary_detect_level;
    logic [1:0] secondary_detect_level;
    logic training_clock_double;
    logic rx_channel_power_on;
    logic self_test_en;
    logic video_rx_en;
    logic test_mode_invalid;
    logic reclock_primary_drive_en;
    logic reclock_secondary_drive_en;
    logic reclock_logic_power_on;
  } drcl_chan_ctrl_t;

endpackage

// *** drcl_top.sv ***
// Top of the two-channel configuration latch bank.
// Host pins come from outside the clock domain and are synchronised here.
`timescale 1ns/1ns

// Operation
// - Clock-rate select 1 (reset value) gives half-rate complementary receive clocks.
// - Clock-rate select 0 gives full-rate complementary receive clocks.
// - Primary detect level: 00 off, 01/10/11 are 140/280/420 mV; reset 10.
// - Secondary detect level uses same codes and reset 10.
// - Training-clock double bit, reset 0, multiplies training clock by two.
// - Receive power bit, reset 0, powers receive loop down at 0.
// - Test mode 01 video, 10 self-test, 00/11 invalid, reset 11.
// - Secondary driver enable, reset 0, powers driver down when 0.
// - Primary driver enable, reset 0, powers driver down when 0.
// - Both driver enables 0 powers down the channel reclocker logic.
// - Device reset clears every serial output driver enable.
// - Don't-care bit positions are ignored on write.
// - Addresses 0,1,2 are channel A banks; 5,6,7 channel B banks.
// - Detect bank: 6:5 secondary level, 4:3 primary level, 0 training double.
// - Strobe low captures 7-bit data into addressed write-only bank.
module drcl_top (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic config_write_strobe_n_in,
  input wire logic [2:0] config_addr_in,
  input wire logic [6:0] config_data_in,
  output drcl_pkg::drcl_chan_ctrl_t chan_a_ctrl_out,
  output drcl_pkg::drcl_chan_ctrl_t chan_b_ctrl_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on host pins
  logic strobe_n_meta_reg;
  logic strobe_n_sync_reg;
  logic [2:0] addr_meta_reg;
  logic [2:0] addr_sync_reg;
  logic [6:0] data_meta_reg;
  logic [6:0] data_sync_reg;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      strobe_n_meta_reg <= 1'h1;
      strobe_n_sync_reg <= 1'h1;
      addr_meta_reg <= 3'h0;
      addr_sync_reg <= 3'h0;
      data_meta_reg <= 7'h00;
      data_sync_reg <= 7'h00;
    end else begin
      strobe_n_meta_reg <= config_write_strobe_n_in;
      strobe_n_sync_reg <= strobe_n_meta_reg;
      addr_meta_reg <= config_addr_in;
      addr_sync_reg <= addr_meta_reg;
      data_meta_reg <= config_data_in;
      data_sync_reg <= data_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; level-sensitive capture while strobe is low
  logic write_en;
  logic [2:0] bank_sel_a;
  logic [2:0] bank_sel_b;

  assign write_en = !strobe_n_sync_reg;

  always_comb begin
    bank_sel_a = 3'h0;
    bank_sel_b = 3'h0;
    unique case (addr_sync_reg)
      drcl_pkg::ADDR_A_CLOCK: bank_sel_a = 3'h1;
      drcl_pkg::ADDR_A_DETECT: bank_sel_a = 3'h2;
      drcl_pkg::ADDR_A_DYN: bank_sel_a = 3'h4;
      drcl_pkg::ADDR_B_CLOCK: bank_sel_b = 3'h1;
      drcl_pkg::ADDR_B_DETECT: bank_sel_b = 3'h2;
      drcl_pkg::ADDR_B_DYN: bank_sel_b = 3'h4;
      default: begin
        bank_sel_a = 3'h0;
        bank_sel_b = 3'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel banks and decode
  drcl_pkg::drcl_chan_cfg_t cfg_a;
  drcl_pkg::drcl_chan_cfg_t cfg_b;
  drcl_pkg::drcl_chan_ctrl_t ctrl_a_next;
  drcl_pkg::drcl_chan_ctrl_t ctrl_b_next;
  drcl_pkg::drcl_chan_ctrl_t ctrl_a_reg;
  drcl_pkg::drcl_chan_ctrl_t ctrl_b_reg;

  drcl_chan_latch u_latch_a (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .write_in(write_en),
    .bank_sel_in(bank_sel_a),
    .data_in(data_sync_reg),
    .cfg_out(cfg_a)
  );

  drcl_chan_latch u_latch_b (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .write_in(write_en),
    .bank_sel_in(bank_sel_b),
    .data_in(data_sync_reg),
    .cfg_out(cfg_b)
  );

  drcl_chan_decode u_dec_a (
    .cfg_in(cfg_a),
    .ctrl_out(ctrl_a_next)
  );

  drcl_chan_decode u_dec_b (
    .cfg_in(cfg_b),
    .ctrl_out(ctrl_b_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; reset forces drivers off at once
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_a_reg <= '0;
      ctrl_b_reg <= '0;
      ctrl_a_reg.rx_clock_half_rate <= drcl_pkg::RST_CLK_RATE;
      ctrl_b_reg.rx_clock_half_rate <= drcl_pkg::RST_CLK_RATE;
      ctrl_a_reg.primary_detect_level <= drcl_pkg::RST_DET;
      ctrl_b_reg.primary_detect_level <= drcl_pkg::RST_DET;
      ctrl_a_reg.secondary_detect_level <= drcl_pkg::RST_DET;
      ctrl_b_reg.secondary_detect_level <= drcl_pkg::RST_DET;
      ctrl_a_reg.test_mode_invalid <= 1'h1;
      ctrl_b_reg.test_mode_invalid <= 1'h1;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
    end
  end

  assign chan_a_ctrl_out = ctrl_a_reg;
  assign chan_b_ctrl_out = ctrl_b_reg;

endmodule

// *** drcl_top_monitor.sv ***
// Checker for the configuration latch bank, bound to its top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module drcl_top_monitor (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic config_write_strobe_n_in,
  input wire logic [2:0] config_addr_in,
  input wire logic [6:0] config_data_in,
  input drcl_pkg::drcl_chan_ctrl_t chan_a_ctrl_out,
  input drcl_pkg::drcl_chan_ctrl_t chan_b_ctrl_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  drcl_pkg::drcl_chan_ctrl_t a;
  drcl_pkg::drcl_chan_ctrl_t b;
  logic [6:0] d_q;
  assign a = chan_a_ctrl_out;
  assign b = chan_b_ctrl_out;
  always_ff @(posedge clock_in) begin
    d_q <= config_data_in;
  end
  // Four steady strobe samples guarantee the write has reached the outputs
  sequence held(logic [2:0] sel);
    (!config_write_strobe_n_in && config_addr_in == sel && $stable(config_data_in))[*4];
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_RST_VALUES: assert property (disable iff (1'b0) reset_in ##1 reset_in |=>
    a == 13'h1A08 && b == 13'h1A08) else $error("reset state wrong");
  AST_LOGIC_PWR: assert property (a.reclock_logic_power_on ==
    (a.reclock_primary_drive_en | a.reclock_secondary_drive_en)) else $error("logic power wrong");
  AST_MODE_EXCL: assert property (!(b.self_test_en && b.video_rx_en) &&
    b.test_mode_invalid == !(b.self_test_en | b.video_rx_en)) else $error("mode flags wrong");
  AST_DYN_WRITE: assert property (held(3'h2) |=> a.rx_channel_power_on == d_q[5] &&
    a.reclock_primary_drive_en == d_q[1] && a.reclock_secondary_drive_en == d_q[2])
    else $error("dynamic bank wrong");
  AST_DET_WRITE: assert property (held(3'h1) |=> {a.secondary_detect_level,
    a.primary_detect_level, a.training_clock_double} == {d_q[6:3], d_q[0]})
    else $error("detect bank wrong");
  AST_CLK_WRITE: assert property (held(3'h5) |=> b.rx_clock_half_rate == d_q[0])
    else $error("clock bank wrong");
  AST_MODE_WRITE: assert property (held(3'h7) |=> b.self_test_en == (d_q[6] & !d_q[4]) &&
    b.video_rx_en == (!d_q[6] & d_q[4])) else $error("test mode wrong");
  // A stray write would first show four samples after the strobe falls
  AST_UNMAPPED: assert property ($fell(config_write_strobe_n_in) &&
    (config_addr_in == 3'h3 || config_addr_in == 3'h4) |-> ##4 ($stable(a) && $stable(b)))
    else $error("test address changed a bank");
  AST_CHAN_ISOL: assert property ($fell(config_write_strobe_n_in) && config_addr_in == 3'h2
    |-> ##4 $stable(b)) else $error("channel b changed");
endmodule

// *** dual_rx_config_latches_tb.sv ***
// Testbench for the configuration latch bank: directed codes, then random writes.
// Assumes the host model drives the pins and the checker is bound below.
`timescale 1ns/1ns
module dual_rx_config_latches_tb;
  logic clock_in = 1'h0;
  logic reset_in = 1'h1;
  logic strobe_n;
  logic [2:0] addr;
  logic [6:0] data;
  drcl_pkg::drcl_chan_ctrl_t ctrl_a;
  drcl_pkg::drcl_chan_ctrl_t ctrl_b;
  logic [6:0] bank [0:7];
  logic [31:0] rng = 32'h1879;
  logic [1:0] c;
  int n_mismatch = 0;
  int tests_run = 0;
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  drcl_host_model host (.clock_in(clock_in), .config_write_strobe_n_out(strobe_n),
    .config_addr_out(addr), .config_data_out(data));
  drcl_top dut (.clock_in(clock_in), .reset_in(reset_in), .config_write_strobe_n_in(strobe_n),
    .config_addr_in(addr), .config_data_in(data), .chan_a_ctrl_out(ctrl_a),
    .chan_b_ctrl_out(ctrl_b));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic drcl_pkg::drcl_chan_ctrl_t expect_ctrl(input logic [6:0] k,
    input logic [6:0] s, input logic [6:0] y);
    drcl_pkg::drcl_chan_ctrl_t e;
    e = {k[0], s[4:3], s[6:5], s[0], y[5], 3'h0, y[1], y[2], y[1] | y[2]};
    e.self_test_en = ({y[6], y[4]} == 2'h2);
    e.video_rx_en = ({y[6], y[4]} == 2'h1);
    e.test_mode_invalid = (y[6] == y[4]);
    return e;
  endfunction
  task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic check_both();
    #5;
    check("chan_a", ctrl_a, expect_ctrl(bank[0], bank[1], bank[2]));
    check("chan_b", ctrl_b, expect_ctrl(bank[5], bank[6], bank[7]));
  endtask
  task automatic wr(input logic [2:0] a, input logic [6:0] d, input int hold);
    host.write_bank(a, d, hold);
    if (a != 3'h3 && a != 3'h4) begin
      bank[a] = d;
    end
    check_both();
  endtask
  task automatic do_reset(input int cycles);
    @(posedge clock_in) #5 reset_in = 1'h1;
    repeat (cycles) @(posedge clock_in);
    #5 reset_in = 1'h0;
    bank = '{7'h01, 7'h50, 7'h50, 7'h00, 7'h00, 7'h01, 7'h50, 7'h50};
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    n_mismatch++;
    final_report();
  end
  initial begin
    do_reset(20);
    check_both();
    // Static banks first, then dynamic, for every field code except channel A's power bit, which is always written as 1
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      rng = xorshift(rng);
      wr(3'h0, {rng[6:1], c[0]}, 4);
      wr(3'h1, {c, ~c, rng[2:1], c[0]}, 4);
      wr(3'h6, {~c, c, rng[4:3], c[1]}, 4);
      wr(3'h5, {rng[6:1], c[1]}, 4);
      wr(3'h2, {c[1], 1'h1, c[0], rng[5], c[0], c[1], rng[7]}, 6);
      wr(3'h7, {c[0], c[1], c[1], rng[8], c[1], c[0], rng[9]}, 4);
    end
    wr(3'h3, rng[6:0], 6);
    wr(3'h4, ~rng[6:0], 6);
    do_reset(3);
    check_both();
    for (int i = 0; i < 40; i++) begin
      rng = xorshift(rng);
      wr(rng[2:0], rng[9:3], 1 + int'(rng[11:10]));
    end
    final_report();
  end
endmodule
bind drcl_top drcl_top_monitor mon (.clock_in(clock_in), .reset_in(reset_in),
  .config_write_strobe_n_in(config_write_strobe_n_in), .config_addr_in(config_addr_in),
  .config_data_in(config_data_in), .chan_a_ctrl_out(chan_a_ctrl_out),
  .chan_b_ctrl_out(chan_b_ctrl_out));
